// >>> common/timers_pkg.sv
// Shared constants for the general purpose timer block.
package timers_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timer numbering: slot 0 is timer one, slots 1 to 4 are timers two to five.
  localparam int NUM_TIMERS = 5;
  localparam int TIMER_ONE  = 0;
  localparam int EVEN_A     = 1;
  localparam int ODD_A      = 2;
  localparam int EVEN_B     = 3;
  localparam int ODD_B      = 4;
  localparam int NUM_PAIRS  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions.
  localparam int RUN_BIT   = 15;
  localparam int IDLE_BIT  = 13;
  localparam int XSRC_HI   = 9;
  localparam int XSRC_LO   = 8;
  localparam int GATE_BIT  = 6;
  localparam int PSC_HI    = 5;
  localparam int PSC_LO    = 4;
  localparam int PAIR_BIT  = 3;
  localparam int SYNC_BIT  = 2;
  localparam int SRC_BIT   = 1;

  // Writable bits of each control register kind; the rest read as zero.
  localparam logic [15:0] ONE_CTRL_MASK  = 16'ha376;
  localparam logic [15:0] EVEN_CTRL_MASK = 16'ha37a;
  localparam logic [15:0] ODD_CTRL_MASK  = 16'ha372;

  // Extended source codes.
  localparam logic [1:0] SRC_SECONDARY    = 2'b00;
  localparam logic [1:0] SRC_PAIR_PIN     = 2'b01;
  localparam logic [1:0] SRC_LOW_POWER_RC = 2'b10;
  localparam logic [1:0] SRC_GENERIC      = 2'b11;

  // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256.
  localparam logic [7:0] PSC_TERM_1   = 8'h00;
  localparam logic [7:0] PSC_TERM_8   = 8'h07;
  localparam logic [7:0] PSC_TERM_64  = 8'h3f;
  localparam logic [7:0] PSC_TERM_256 = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: each timer owns a 16-byte block with three words in use.
  localparam int          ADDR_W       = 8;
  localparam logic [3:0]  CTRL_OFF     = 4'h0;
  localparam logic [3:0]  COUNT_OFF    = 4'h4;
  localparam logic [3:0]  PERIOD_OFF   = 4'h8;
  localparam logic [7:0]  FLAG_OFF     = 8'h50;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

endpackage

// >>> rtl/general_purpose_timers.sv
// Timer one plus timers two to five with 32-bit pairing, behind an APB slave.
`timescale 1ns/10ps

// Behaviour
// - Timer one: internal, synced or unsynced external
// - Interrupt on period match or gate fall
// - Run control bit starts and stops
// - Idle-stop bit halts timer in idle
// - Extended source field picks external clock
// - Gate enable only with internal clock
// - Prescale 1, 8, 64 or 256
// - Timer one sync bit chooses synchroniser
// - Source select: extended source or internal
// - Control write clears prescale counter
// - Timers two-five synchronous only, pairable
// - Pair uses even control, odd flag
// - Odd period high word, even low
// - Odd count high word, even low
// - ADC event from pair A or timer three
// - Pair mode bit joins even and odd
// - Even run control drives whole pair
// - Internal source ignores field; 01 paired pin
// - Pair interrupts on 32-bit period match
// - Odd timer external clock on rising edge
module general_purpose_timers
  import timers_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Device state and clock sources
  input  wire logic                  idle_mode,
  input  wire logic                  secondary_oscillator,
  input  wire logic                  low_power_rc_osc,
  input  wire logic                  generic_timer_pin,
  input  wire logic [NUM_TIMERS-1:0] timer_pin,
  // Events
  output logic [NUM_TIMERS-1:0]      irq_flag,
  output logic                       adc_event
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [15:0]           ctrl      [NUM_TIMERS];
  logic [15:0]           count     [NUM_TIMERS];
  logic [15:0]           period    [NUM_TIMERS];
  logic [7:0]            psc       [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] sync_a;
  logic [NUM_TIMERS-1:0] sync_b;
  logic [NUM_TIMERS-1:0] src_prev;
  logic [NUM_TIMERS-1:0] gate_a;
  logic [NUM_TIMERS-1:0] gate_b;
  logic [NUM_TIMERS-1:0] gate_prev;

  // Per-slot decoded behaviour.
  logic [15:0]           ctl_eff   [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] ext_raw;
  logic [NUM_TIMERS-1:0] src_lvl;
  logic [NUM_TIMERS-1:0] in_pulse;
  logic [NUM_TIMERS-1:0] running;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] gate_fall;
  logic [NUM_TIMERS-1:0] solo;
  logic [NUM_TIMERS-1:0] match16;
  logic [NUM_TIMERS-1:0] flag_set;
  logic [7:0]            psc_term  [NUM_TIMERS];
  logic [NUM_PAIRS-1:0]  pair_on;
  logic [NUM_PAIRS-1:0]  pair_match;

  // Bus decode.
  logic                  acc_setup;
  logic                  acc_write;
  logic                  dec_hit;
  logic                  dec_flag;
  logic [2:0]            dec_idx;
  logic [3:0]            dec_reg;
  logic [31:0]           next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Slot helpers.
  function automatic int even_of(input int i);
    return (i <= ODD_A) ? EVEN_A : EVEN_B;
  endfunction

  function automatic int ctl_idx(input int i, input logic [1:0] pairs);
    if ((i == ODD_A && pairs[0]) || (i == ODD_B && pairs[1])) begin
      return i - 1;
    end
    return i;
  endfunction

  function automatic logic [15:0] ctrl_mask(input int i);
    if (i == TIMER_ONE) begin
      return ONE_CTRL_MASK;
    end
    return (i == EVEN_A || i == EVEN_B) ? EVEN_CTRL_MASK : ODD_CTRL_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source selection, gating and prescaler ticks.
  assign pair_on[0] = ctrl[EVEN_A][PAIR_BIT];
  assign pair_on[1] = ctrl[EVEN_B][PAIR_BIT];

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ctl_eff[i] = ctrl[ctl_idx(i, pair_on)];
      // Extended source mux; only consulted when source select is set.
      case (ctl_eff[i][XSRC_HI:XSRC_LO])
        SRC_SECONDARY:    ext_raw[i] = secondary_oscillator;
        SRC_LOW_POWER_RC: ext_raw[i] = low_power_rc_osc;
        SRC_PAIR_PIN:     ext_raw[i] = (i == TIMER_ONE) ? timer_pin[i]
                                       : timer_pin[even_of(i) + 1];
        SRC_GENERIC:      ext_raw[i] = (i == TIMER_ONE) ? generic_timer_pin
                                       : timer_pin[even_of(i)];
        default:          ext_raw[i] = 1'b0;
      endcase
      // Only timer one may bypass the synchroniser.
      src_lvl[i] = (i == TIMER_ONE && !ctl_eff[i][SYNC_BIT]) ? ext_raw[i]
                   : sync_b[i];
      if (ctl_eff[i][SRC_BIT]) begin
        in_pulse[i] = src_lvl[i] & ~src_prev[i];
      end else if (ctl_eff[i][GATE_BIT]) begin
        in_pulse[i] = gate_b[i];
      end else begin
        in_pulse[i] = 1'b1;
      end
      gate_fall[i] = !ctl_eff[i][SRC_BIT] && ctl_eff[i][GATE_BIT]
                     && gate_prev[i] && !gate_b[i];
      running[i]   = ctl_eff[i][RUN_BIT]
                     && !(ctl_eff[i][IDLE_BIT] && idle_mode);
      case (ctl_eff[i][PSC_HI:PSC_LO])
        2'b00:   psc_term[i] = PSC_TERM_1;
        2'b01:   psc_term[i] = PSC_TERM_8;
        2'b10:   psc_term[i] = PSC_TERM_64;
        default: psc_term[i] = PSC_TERM_256;
      endcase
      tick[i] = running[i] && in_pulse[i] && (psc[i] == psc_term[i]);
      solo[i] = !((i == EVEN_A || i == ODD_A) && pair_on[0])
                && !((i == EVEN_B || i == ODD_B) && pair_on[1]);
      match16[i] = solo[i] && tick[i] && (count[i] == period[i]);
    end
    pair_match[0] = pair_on[0] && tick[EVEN_A]
                    && ({count[ODD_A], count[EVEN_A]}
                        == {period[ODD_A], period[EVEN_A]});
    pair_match[1] = pair_on[1] && tick[EVEN_B]
                    && ({count[ODD_B], count[EVEN_B]}
                        == {period[ODD_B], period[EVEN_B]});
    // Paired events land on the odd slot's flag.
    for (int i = 0; i < NUM_TIMERS; i++) begin
      flag_set[i] = match16[i] || (solo[i] && gate_fall[i]);
    end
    flag_set[ODD_A] = flag_set[ODD_A] || pair_match[0]
                      || (pair_on[0] && gate_fall[EVEN_A]);
    flag_set[ODD_B] = flag_set[ODD_B] || pair_match[1]
                      || (pair_on[1] && gate_fall[EVEN_B]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge history for clock and gate inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a    <= '0;
      sync_b    <= '0;
      src_prev  <= '0;
      gate_a    <= '0;
      gate_b    <= '0;
      gate_prev <= '0;
    end else if (clk_en) begin
      sync_a    <= ext_raw;
      sync_b    <= sync_a;
      src_prev  <= src_lvl;
      gate_a    <= timer_pin;
      gate_b    <= gate_a;
      gate_prev <= gate_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  assign acc_setup = psel && !penable;
  assign acc_write = psel && penable && pready && pwrite;
  assign dec_idx   = paddr[6:4];
  assign dec_reg   = paddr[3:0];
  assign dec_flag  = (paddr == FLAG_OFF);
  assign dec_hit   = dec_flag
                     || (paddr < FLAG_OFF && (dec_reg == CTRL_OFF
                         || dec_reg == COUNT_OFF || dec_reg == PERIOD_OFF));

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (dec_flag) begin
      next_rdata[NUM_TIMERS-1:0] = irq_flag;
    end else if (dec_hit) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (dec_idx == 3'(i)) begin
          case (dec_reg)
            CTRL_OFF:  next_rdata[15:0] = ctrl[i];
            COUNT_OFF: next_rdata[15:0] = count[i];
            default:   next_rdata[15:0] = period[i];
          endcase
        end
      end
    end
  end

  // Zero wait states: ready is raised for the access phase after each setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= acc_setup;
      pslverr <= acc_setup && !dec_hit;
      if (acc_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and period registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl[i]   <= CTRL_RESET;
        period[i] <= PERIOD_RESET;
      end
    end else if (clk_en && acc_write && dec_hit && !dec_flag) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (dec_idx == 3'(i) && dec_reg == CTRL_OFF) begin
          ctrl[i] <= pwdata[15:0] & ctrl_mask(i);
        end
        if (dec_idx == 3'(i) && dec_reg == PERIOD_OFF) begin
          period[i] <= pwdata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        psc[i] <= 8'h00;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (acc_write && dec_idx == 3'(i) && dec_reg == CTRL_OFF
            && !dec_flag) begin
          psc[i] <= 8'h00;
        end else if (running[i] && in_pulse[i]) begin
          psc[i] <= (psc[i] == psc_term[i]) ? 8'h00 : psc[i] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters; a software write to a count word wins over a tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        count[i] <= COUNT_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (solo[i] && tick[i]) begin
          count[i] <= match16[i] ? COUNT_RESET : count[i] + 16'h0001;
        end
      end
      if (pair_on[0] && tick[EVEN_A]) begin
        if (pair_match[0]) begin
          count[ODD_A]  <= COUNT_RESET;
          count[EVEN_A] <= COUNT_RESET;
        end else begin
          {count[ODD_A], count[EVEN_A]} <=
            {count[ODD_A], count[EVEN_A]} + 32'h0000_0001;
        end
      end
      if (pair_on[1] && tick[EVEN_B]) begin
        if (pair_match[1]) begin
          count[ODD_B]  <= COUNT_RESET;
          count[EVEN_B] <= COUNT_RESET;
        end else begin
          {count[ODD_B], count[EVEN_B]} <=
            {count[ODD_B], count[EVEN_B]} + 32'h0000_0001;
        end
      end
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (acc_write && !dec_flag && dec_idx == 3'(i)
            && dec_reg == COUNT_OFF) begin
          count[i] <= pwdata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request flags (write one to clear, a set wins) and ADC event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag <= '0;
    end else if (clk_en) begin
      if (acc_write && dec_flag) begin
        irq_flag <= (irq_flag & ~pwdata[NUM_TIMERS-1:0]) | flag_set;
      end else begin
        irq_flag <= irq_flag | flag_set;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_event <= 1'b0;
    end else if (clk_en) begin
      adc_event <= pair_on[0] ? pair_match[0] : match16[ODD_A];
    end
  end

endmodule

// >>> tb/timers_asserts.sv
// Concurrent checks on the bus handshake, flags and converter event.
`timescale 1ns/10ps
module timers_asserts
  import timers_pkg::*;
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  clk_en,
  // Bus
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_W-1:0]     paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // Events
  input wire logic [NUM_TIMERS-1:0] irq_flag,
  input wire logic                  adc_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic clear_wr;
  assign clear_wr = psel && penable && pwrite && pready && paddr == FLAG_OFF;

  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence access_s;
    setup_s ##1 (psel && penable && pready && clk_en);
  endsequence

  AST_READY_ONE: assert property (setup_s |=> pready)
    else $error("no answer one cycle after setup");
  AST_READY_PULSE: assert property (access_s |=> !pready)
    else $error("ready held past the access cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without a setup cycle");
  AST_ERR_MAP: assert property (setup_s ##0 (paddr > 8'h50 ||
    paddr[3:0] == 4'hc) |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 0)
    else $error("upper read bits not zero");
  AST_ADC_FLAG: assert property (adc_event |-> irq_flag[ODD_A])
    else $error("converter event without timer three flag");
  AST_FLAG_STICKY: assert property (|($past(irq_flag) & ~irq_flag) |->
    $past(clear_wr) && ($past(irq_flag) & ~irq_flag & ~$past(pwdata[4:0]))
    == 5'h0)
    else $error("flag dropped without a clear write");
endmodule

bind general_purpose_timers timers_asserts chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .irq_flag(irq_flag), .adc_event(adc_event)
);

// >>> tb/tb_top.sv
// Self-checking bench for the general purpose timer block.
`timescale 1ns/10ps
module tb_top
  import timers_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        idle_mode = 0, secondary_oscillator = 0, clk_en = 1;
  logic        low_power_rc_osc = 0, generic_timer_pin = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [4:0]  timer_pin = 0;
  logic        berr;
  wire         pready, pslverr, adc_event;
  wire  [31:0] prdata;
  wire  [4:0]  irq_flag;
  int          err_total = 0, compares = 0, adc_count = 0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (adc_event === 1'b1) adc_count <= adc_count + 1;

  general_purpose_timers dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .idle_mode(idle_mode), .secondary_oscillator(secondary_oscillator),
    .low_power_rc_osc(low_power_rc_osc),
    .generic_timer_pin(generic_timer_pin), .timer_pin(timer_pin),
    .irq_flag(irq_flag), .adc_event(adc_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_in(input int n, input int lo, input int hi);
    check(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    berr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic wait_flag(input int b, input int lim, output int n);
    n = 0;
    while (irq_flag[b] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (irq_flag[b] !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask
  // Stops a timer, clears its count and all flags, then starts it.
  task automatic prep(input logic [7:0] b, input logic [15:0] per,
                      input logic [15:0] c);
    wr(b, 32'h0);
    wr(b + 8'h4, 32'h0);
    wr(b + 8'h8, {16'h0, per});
    wr(FLAG_OFF, 32'h1f);
    wr(b, {16'h0, c});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] msk [3];
    msk = '{16'ha376, 16'ha37a, 16'ha372};
    for (int s = 0; s < 5; s++) begin
      bus(1'b0, 8'(s * 16), 32'h0);
      check(rd, 32'h0);
      bus(1'b0, 8'(s * 16 + 8), 32'h0);
      check(rd, 32'h0000ffff);
    end
    for (int s = 0; s < 3; s++) begin
      wr(8'(s * 16), 32'hffffffff);
      bus(1'b0, 8'(s * 16), 32'h0);
      check(rd, {16'h0, msk[s]});
      wr(8'(s * 16), 32'h0);
    end
    bus(1'b0, 8'h5c, 32'h0);
    check({berr, rd[30:0]}, 32'h80000000);
    $display("done: registers");
  endtask

  task automatic t_prescale();
    int rt [4];
    int n;
    rt = '{1, 8, 64, 256};
    for (int p = 0; p < 4; p++) begin
      prep(8'h00, 16'h1, 16'h8000 | 16'(p << 4));
      wait_flag(0, 600, n);
      check_in(n, 2 * rt[p] - 3, 2 * rt[p] + 3);
    end
    prep(8'h00, 16'h0, 16'h8030);
    repeat (200) @(posedge pclk);
    wr(8'h00, 32'h8030);
    wait_flag(0, 300, n);
    check_in(n, 250, 262);
    idle_mode <= 1'b1;
    prep(8'h00, 16'h1, 16'ha000);
    repeat (20) @(posedge pclk);
    check(irq_flag[0], 1'b0);
    idle_mode <= 1'b0;
    wait_flag(0, 10, n);
    idle_mode <= 1'b1;
    prep(8'h00, 16'h1, 16'h8000);
    wait_flag(0, 10, n);
    idle_mode <= 1'b0;
    $display("done: prescale and idle");
  endtask

  task automatic set_src(input int c, input logic v);
    case (c)
      0: secondary_oscillator <= v;
      1: timer_pin[0] <= v;
      2: low_power_rc_osc <= v;
      default: generic_timer_pin <= v;
    endcase
  endtask
  task automatic t_external();
    int n;
    for (int c = 0; c < 4; c++) begin
      prep(8'h00, 16'h1, 16'h8002 | 16'(c << 8) | 16'((c % 2) << 2));
      repeat (20) @(posedge pclk);
      check(irq_flag[0], 1'b0);
      repeat (2) begin
        set_src(c, 1'b1);
        repeat (4) @(posedge pclk);
        set_src(c, 1'b0);
        repeat (4) @(posedge pclk);
      end
      wait_flag(0, 10, n);
    end
    prep(8'h00, 16'hffff, 16'h8040);
    timer_pin[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    check(irq_flag[0], 1'b0);
    timer_pin[0] <= 1'b0;
    wait_flag(0, 8, n);
    bus(1'b0, 8'h04, 32'h0);
    check_in(int'(rd[15:0]), 7, 13);
    wr(8'h00, 32'h0);
    $display("done: external and gate");
  endtask

  task automatic t_pair();
    int n, a0;
    wr(8'h10, 32'h0008);
    wr(8'h20, 32'h8030);
    wr(8'h24, 32'h0);
    wr(8'h14, 32'hfffd);
    wr(8'h28, 32'h1);
    wr(8'h18, 32'h1);
    wr(FLAG_OFF, 32'h1f);
    a0 = adc_count;
    wr(8'h10, 32'h8008);
    wait_flag(ODD_A, 12, n);
    check_in(n, 3, 8);
    check(irq_flag[EVEN_A], 1'b0);
    wr(8'h10, 32'h0008);
    bus(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    check_in(int'(rd), 1, 5);
    check(32'(adc_count - a0), 32'h1);
    wr(8'h10, 32'h0);
    a0 = adc_count;
    prep(8'h10, 16'h1, 16'h8000);
    wait_flag(EVEN_A, 10, n);
    wr(8'h10, 32'h0);
    check(32'(adc_count - a0), 32'h0);
    prep(8'h20, 16'h1, 16'h8000);
    wait_flag(ODD_A, 10, n);
    wr(8'h20, 32'h0);
    check(32'(adc_count > a0), 32'h1);
    $display("done: pairing");
  endtask

  // Freeze by clock enable, timer five on its own pin, then the second pair.
  task automatic t_more();
    int n, a0, c0;
    prep(8'h00, 16'hffff, 16'h8000);
    bus(1'b0, 8'h04, 32'h0);
    c0 = int'(rd[15:0]);
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    check_in(int'(rd[15:0]) - c0, 1, 5);
    wr(8'h00, 32'h0);
    prep(8'h40, 16'h1, 16'h8102);
    repeat (10) @(posedge pclk);
    check(irq_flag[ODD_B], 1'b0);
    repeat (2) begin
      timer_pin[ODD_B] <= 1'b1;
      repeat (4) @(posedge pclk);
      timer_pin[ODD_B] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    wait_flag(ODD_B, 10, n);
    check(irq_flag[EVEN_B], 1'b0);
    wr(8'h40, 32'h0);
    wr(8'h30, 32'h0008);
    wr(8'h44, 32'h0);
    wr(8'h34, 32'hfffe);
    wr(8'h48, 32'h1);
    wr(8'h38, 32'h0);
    wr(FLAG_OFF, 32'h1f);
    a0 = adc_count;
    wr(8'h30, 32'h8008);
    wait_flag(ODD_B, 10, n);
    check_in(n, 2, 6);
    check(irq_flag[EVEN_B], 1'b0);
    wr(8'h30, 32'h0);
    check(32'(adc_count - a0), 32'h0);
    $display("done: freeze, timer five and second pair");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_prescale();
    t_external();
    t_pair();
    t_more();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    end_of_test();
  end
endmodule
